/* File: occt_consts.vh */
// constants for the output channel calibration tag block
// ---------------------------------------------------------------
// Summary of operation
// ---------------------------------------------------------------
// Summary of operation
// - valid delivered reference sets its good flag
// - bad low point, abandon sets fault
// - bad high point, abandon sets fault
// - success flag holds while connection open, until the next calibration start clears it
// - free 15-bit millisecond counter, 0 to 32767
// - echo change captures millisecond counter
// - echo reports value driven at terminal block
// - low release rising edge clears low alarm
// - high release rising edge clears high alarm
// - slew release rising edge clears slew alarm
// - calibrate command at 1 starts calibration
// - drive low point command rise drives low
// - drive high point command rise drives high
// - low delivered rise records data word
// - high delivered rise records data word
// - complete command change finishes valid calibration
// - outside calibration data word is driven
// - fault flag cleared by power cycle or by a successful calibration
// - calibrating flag reads 1 during calibration
`ifndef OCCT_CONSTS_VH
`define OCCT_CONSTS_VH

// ---------------------------------------------------------------
// register map (byte addresses, one word each)
// ---------------------------------------------------------------
`define OCCT_AW 8
`define OCCT_CH_SHIFT 4
`define OCCT_CH_STRIDE 8'h10
`define OCCT_OFF_DATA 4'h0
`define OCCT_OFF_CMD 4'h4
`define OCCT_OFF_STAT 4'h8
`define OCCT_OFF_ECHO 4'hc
`define OCCT_ADDR_STAMP_BASE 8'h40
`define OCCT_ADDR_MSCNT 8'h50
`define OCCT_ADDR_REF_BASE 8'h60

// ---------------------------------------------------------------
// command word fields
// ---------------------------------------------------------------
`define OCCT_CMD_W 9
`define OCCT_CMD_CAL 0
`define OCCT_CMD_DRV_LO 1
`define OCCT_CMD_DRV_HI 2
`define OCCT_CMD_LO_DLV 3
`define OCCT_CMD_HI_DLV 4
`define OCCT_CMD_DONE 5
`define OCCT_CMD_REL_LO 6
`define OCCT_CMD_REL_HI 7
`define OCCT_CMD_REL_SLEW 8

// ---------------------------------------------------------------
// status word fields
// ---------------------------------------------------------------
`define OCCT_ST_LO_OK 0
`define OCCT_ST_LO_BAD 1
`define OCCT_ST_HI_OK 2
`define OCCT_ST_HI_BAD 3
`define OCCT_ST_DONE_OK 4
`define OCCT_ST_FAIL 5
`define OCCT_ST_CALING 6
`define OCCT_ST_ALM_LO 7
`define OCCT_ST_ALM_HI 8
`define OCCT_ST_ALM_SLEW 9

// ---------------------------------------------------------------
// numbers and timing
// ---------------------------------------------------------------
`define OCCT_NCH 4
`define OCCT_STAMP_W 15
`define OCCT_STAMP_MAX 15'h7fff
`define OCCT_CLK_MHZ 100
`define OCCT_MS_US 1000
`define OCCT_EXP_ALL1 8'hff
`define OCCT_LO_POINT 32'h40800000
`define OCCT_HI_POINT 32'h41a00000
`define OCCT_ZERO32 32'h00000000

`endif

/* File: occt_ctrl_model.sv */
// owner controller model: bus master sending channel tag updates
module occt_ctrl_model (
  input wire clock_in,
  output reg [7:0] addr_out,
  output reg [31:0] wdata_out,
  output reg wr_out,
  output reg rd_out,
  input wire [31:0] rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    addr_out = 8'h00;
    wdata_out = 32'h00000000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one write cycle, then a gap; released lines are inverted so stale values never match
  task bus_wr(input [7:0] a, input [31:0] d);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clock_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
    @(posedge clock_in);
  endtask
  // one read cycle; the answer stands only in the following cycle
  task bus_rd(input [7:0] a, output [31:0] d);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clock_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clock_in);
    d = rdata_in;
  endtask
  // command word of one channel, never asking for both reference points
  task send_cmd(input [3:0] ch, input [8:0] c);
    reg [8:0] v;
    v = c;
    if (v[1]) v[2] = 1'b0;
    bus_wr({ch, 4'h4}, {23'h0, v});
  endtask
endmodule

/* File: occt_ref_mem.v */
// small memory for recorded calibration reference words
module occt_ref_mem (
  input wire clock_in,
  input wire wr_en_in,
  input wire [2:0] wr_addr_in,
  input wire [31:0] wr_data_in,
  input wire [2:0] rd_addr_in,
  output reg [31:0] rd_data_out
);
  // ---------------------------------------------------------------
  // storage: two words per channel, low point then high point
  // ---------------------------------------------------------------
  reg [31:0] mem_q [0:7];

  // write port and registered read port; no reset, contents are data
  always @(posedge clock_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_q[rd_addr_in];
  end
endmodule

/* File: occt_top.v */
// output channel calibration tag handshake, four channels
//
// Added by the designer: the address-and-strobe port and the address map.
`include "occt_consts.vh"
module occt_top #(
  parameter MS_CYCLES = `OCCT_CLK_MHZ * `OCCT_MS_US
) (
  input wire clock_in,
  input wire rst_n_in,
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output wire [31:0] rdata_out,
  input wire conn_open_in,
  input wire [3:0] low_clamp_alarm_in,
  input wire [3:0] high_clamp_alarm_in,
  input wire [3:0] slew_alarm_in,
  output reg [127:0] terminal_block_out,
  output wire [3:0] calibrating_out,
  output reg [3:0] low_clamp_alarm_out,
  output reg [3:0] high_clamp_alarm_out,
  output reg [3:0] slew_alarm_out
);
  // ---------------------------------------------------------------
  // state codes and functions
  // ---------------------------------------------------------------
  localparam ST_RUN = 1'b0; // normal output
  localparam ST_CAL = 1'b1; // calibrating
  localparam DRV_DATA = 2'b00; // no point chosen: data word when running, last value held while calibrating
  localparam DRV_LO = 2'b01; // drive low point
  localparam DRV_HI = 2'b10; // drive high point

  // a word is usable as reference only when it is a finite real
  function is_finite;
    input [31:0] w;
    begin
      is_finite = (w[30:23] != `OCCT_EXP_ALL1);
    end
  endfunction

  // 0 to 1 step between previous and current update
  function rose;
    input now_v;
    input old_v;
    begin
      rose = now_v & ~old_v;
    end
  endfunction

  // ---------------------------------------------------------------
  // per channel storage
  // ---------------------------------------------------------------
  reg [31:0] data_q [0:3]; // last data word written
  reg [`OCCT_CMD_W-1:0] prev_q [0:3]; // tags of previous update
  reg [3:0] state_q; // calibration state per channel
  reg [1:0] drv_sel_q [0:3]; // what the channel drives
  reg [3:0] lo_ok_q;
  reg [3:0] lo_bad_q;
  reg [3:0] hi_ok_q;
  reg [3:0] hi_bad_q;
  reg [3:0] done_ok_q;
  reg [3:0] fail_q;
  reg [`OCCT_STAMP_W-1:0] stamp_q [0:3];
  reg [`OCCT_STAMP_W-1:0] ms_cnt_q; // free running milliseconds
  reg [16:0] tick_cnt_q; // cycles inside one millisecond
  reg [31:0] rd_q; // registered read data
  reg mem_sel_q; // read answer comes from the memory

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire [1:0] ch_sel = addr_in[5:4]; // channel of a per channel word
  wire ch_space = (addr_in < `OCCT_ADDR_STAMP_BASE);
  wire [3:0] off_sel = addr_in[3:0];
  wire wr_data = wr_in & ch_space & (off_sel == `OCCT_OFF_DATA);
  wire wr_cmd = wr_in & ch_space & (off_sel == `OCCT_OFF_CMD);
  wire ref_space = (addr_in >= `OCCT_ADDR_REF_BASE) &&
                   (addr_in < `OCCT_ADDR_REF_BASE + 8'h20);
  wire [7:0] ref_off = addr_in - `OCCT_ADDR_REF_BASE;
  wire [`OCCT_CMD_W-1:0] cmd_new = wdata_in[`OCCT_CMD_W-1:0];
  wire [`OCCT_CMD_W-1:0] cmd_old = prev_q[ch_sel];

  // ---------------------------------------------------------------
  // transitions of the update being taken (a cmd write)
  // ---------------------------------------------------------------
  wire in_cal = (state_q[ch_sel] == ST_CAL);
  wire t_cal_on = cmd_new[`OCCT_CMD_CAL];
  wire t_cal_off = ~cmd_new[`OCCT_CMD_CAL];
  wire t_drv_lo = rose(cmd_new[`OCCT_CMD_DRV_LO], cmd_old[`OCCT_CMD_DRV_LO]);
  wire t_drv_hi = rose(cmd_new[`OCCT_CMD_DRV_HI], cmd_old[`OCCT_CMD_DRV_HI]);
  wire t_lo_dlv = rose(cmd_new[`OCCT_CMD_LO_DLV], cmd_old[`OCCT_CMD_LO_DLV]);
  wire t_hi_dlv = rose(cmd_new[`OCCT_CMD_HI_DLV], cmd_old[`OCCT_CMD_HI_DLV]);
  // completion reacts to any change of its bit, either direction
  wire t_done = cmd_new[`OCCT_CMD_DONE] ^ cmd_old[`OCCT_CMD_DONE];
  wire t_rel_lo = rose(cmd_new[`OCCT_CMD_REL_LO], cmd_old[`OCCT_CMD_REL_LO]);
  wire t_rel_hi = rose(cmd_new[`OCCT_CMD_REL_HI], cmd_old[`OCCT_CMD_REL_HI]);
  wire t_rel_sl = rose(cmd_new[`OCCT_CMD_REL_SLEW], cmd_old[`OCCT_CMD_REL_SLEW]);
  wire [31:0] cur_data = data_q[ch_sel];
  wire data_fin = is_finite(cur_data);
  // both points valid and neither bad: calibration can finish
  wire cal_good = lo_ok_q[ch_sel] & hi_ok_q[ch_sel] &
                  ~lo_bad_q[ch_sel] & ~hi_bad_q[ch_sel];

  // ---------------------------------------------------------------
  // reference memory: low point at ch*2, high point at ch*2+1
  // ---------------------------------------------------------------
  // if both delivered flags rise in one update the low word wins
  wire mem_we = wr_cmd & in_cal & (t_lo_dlv | t_hi_dlv);
  wire [2:0] mem_wa = {ch_sel, ~t_lo_dlv};
  wire [2:0] mem_ra = ref_off[4:2];
  wire [31:0] mem_rd;

  occt_ref_mem u_mem (
    .clock_in(clock_in),
    .wr_en_in(mem_we),
    .wr_addr_in(mem_wa),
    .wr_data_in(cur_data),
    .rd_addr_in(mem_ra),
    .rd_data_out(mem_rd)
  );

  // ---------------------------------------------------------------
  // millisecond timebase
  // ---------------------------------------------------------------
  // counter wraps from 32767 to 0 by a compare with OCCT_STAMP_MAX
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_q <= 17'h00000;
      ms_cnt_q <= 15'h0000;
    end else if (tick_cnt_q == MS_CYCLES - 1) begin
      tick_cnt_q <= 17'h00000;
      ms_cnt_q <= (ms_cnt_q == `OCCT_STAMP_MAX) ? 15'h0000 : ms_cnt_q + 15'h0001;
    end else begin
      tick_cnt_q <= tick_cnt_q + 17'h00001;
    end
  end

  // ---------------------------------------------------------------
  // data words and previous tag copies
  // ---------------------------------------------------------------
  // data write only stores; the cmd write is what takes an update
  always @(posedge clock_in or negedge rst_n_in) begin : data_words
    // each process owns its loop index, so no variable has two drivers
    integer i;
    if (!rst_n_in) begin
      for (i = 0; i < `OCCT_NCH; i = i + 1) begin
        data_q[i] <= `OCCT_ZERO32;
        prev_q[i] <= {`OCCT_CMD_W{1'b0}};
      end
    end else begin
      if (wr_data) begin
        data_q[ch_sel] <= wdata_in;
      end
      if (wr_cmd) begin
        prev_q[ch_sel] <= cmd_new;
      end
    end
  end

  // ---------------------------------------------------------------
  // calibration state machine and flags
  // ---------------------------------------------------------------
  always @(posedge clock_in or negedge rst_n_in) begin : cal_fsm
    integer i;
    if (!rst_n_in) begin
      state_q <= 4'h0;
      lo_ok_q <= 4'h0;
      lo_bad_q <= 4'h0;
      hi_ok_q <= 4'h0;
      hi_bad_q <= 4'h0;
      done_ok_q <= 4'h0;
      fail_q <= 4'h0;
      for (i = 0; i < `OCCT_NCH; i = i + 1) begin
        drv_sel_q[i] <= DRV_DATA;
      end
    end else begin
      // a closed connection drops every success flag
      if (!conn_open_in) begin
        done_ok_q <= 4'h0;
      end
      if (wr_cmd) begin
        case (state_q[ch_sel])
          ST_RUN: begin
            if (t_cal_on) begin
              // fresh attempt: forget earlier points
              state_q[ch_sel] <= ST_CAL;
              lo_ok_q[ch_sel] <= 1'b0;
              lo_bad_q[ch_sel] <= 1'b0;
              hi_ok_q[ch_sel] <= 1'b0;
              hi_bad_q[ch_sel] <= 1'b0;
              done_ok_q[ch_sel] <= 1'b0;
              drv_sel_q[ch_sel] <= DRV_DATA;
            end
          end
          ST_CAL: begin
            // drive command picks the reference point
            if (t_drv_lo) begin
              drv_sel_q[ch_sel] <= DRV_LO;
            end else if (t_drv_hi) begin
              drv_sel_q[ch_sel] <= DRV_HI;
            end
            // delivered points are judged on the data word
            if (t_lo_dlv) begin
              lo_ok_q[ch_sel] <= data_fin;
              lo_bad_q[ch_sel] <= ~data_fin;
            end
            if (t_hi_dlv) begin
              hi_ok_q[ch_sel] <= data_fin;
              hi_bad_q[ch_sel] <= ~data_fin;
            end
            if (t_done && cal_good) begin
              // completion leaves calibration only when it worked
              state_q[ch_sel] <= ST_RUN;
              done_ok_q[ch_sel] <= conn_open_in;
              fail_q[ch_sel] <= 1'b0;
              drv_sel_q[ch_sel] <= DRV_DATA;
            end else if (t_cal_off) begin
              // abandoned: a bad point marks the channel failed
              state_q[ch_sel] <= ST_RUN;
              drv_sel_q[ch_sel] <= DRV_DATA;
              if (lo_bad_q[ch_sel] | hi_bad_q[ch_sel]) begin
                fail_q[ch_sel] <= 1'b1;
              end
            end
          end
          default: begin
            state_q[ch_sel] <= ST_RUN;
          end
        endcase
      end
    end
  end

  assign calibrating_out = state_q;

  // ---------------------------------------------------------------
  // latched alarms: events set, release rising edge clears
  // ---------------------------------------------------------------
  // set wins over a release arriving in the same cycle
  always @(posedge clock_in or negedge rst_n_in) begin : alarm_latch
    integer i;
    if (!rst_n_in) begin
      low_clamp_alarm_out <= 4'h0;
      high_clamp_alarm_out <= 4'h0;
      slew_alarm_out <= 4'h0;
    end else begin
      for (i = 0; i < `OCCT_NCH; i = i + 1) begin
        if (low_clamp_alarm_in[i]) begin
          low_clamp_alarm_out[i] <= 1'b1;
        end else if (wr_cmd && ch_sel == i && t_rel_lo) begin
          low_clamp_alarm_out[i] <= 1'b0;
        end
        if (high_clamp_alarm_in[i]) begin
          high_clamp_alarm_out[i] <= 1'b1;
        end else if (wr_cmd && ch_sel == i && t_rel_hi) begin
          high_clamp_alarm_out[i] <= 1'b0;
        end
        if (slew_alarm_in[i]) begin
          slew_alarm_out[i] <= 1'b1;
        end else if (wr_cmd && ch_sel == i && t_rel_sl) begin
          slew_alarm_out[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // terminal block drive, echo and change stamp
  // ---------------------------------------------------------------
  // drive value one cycle after state and data settle
  reg [31:0] drv_d [0:3];
  always @* begin : drive_mux
    integer i;
    i = 0;
    for (i = 0; i < `OCCT_NCH; i = i + 1) begin
      if (state_q[i] == ST_RUN) begin
        drv_d[i] = data_q[i];
      end else begin
        case (drv_sel_q[i])
          DRV_LO: drv_d[i] = `OCCT_LO_POINT;
          DRV_HI: drv_d[i] = `OCCT_HI_POINT;
          default: drv_d[i] = terminal_block_out[i*32 +: 32];
        endcase
      end
    end
  end

  // the stamp follows the echo, so it moves only on a real change
  always @(posedge clock_in or negedge rst_n_in) begin : echo_stamp
    integer i;
    if (!rst_n_in) begin
      terminal_block_out <= 128'h0;
      for (i = 0; i < `OCCT_NCH; i = i + 1) begin
        stamp_q[i] <= 15'h0000;
      end
    end else begin
      for (i = 0; i < `OCCT_NCH; i = i + 1) begin
        terminal_block_out[i*32 +: 32] <= drv_d[i];
        if (drv_d[i] != terminal_block_out[i*32 +: 32]) begin
          stamp_q[i] <= ms_cnt_q;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // register read: answer in the cycle after the strobe
  // ---------------------------------------------------------------
  wire [31:0] stat_word = {22'h000000,
    slew_alarm_out[ch_sel], high_clamp_alarm_out[ch_sel],
    low_clamp_alarm_out[ch_sel], state_q[ch_sel], fail_q[ch_sel],
    done_ok_q[ch_sel], hi_bad_q[ch_sel], hi_ok_q[ch_sel],
    lo_bad_q[ch_sel], lo_ok_q[ch_sel]};

  // unmapped addresses read as zero
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_q <= `OCCT_ZERO32;
      mem_sel_q <= 1'b0;
    end else begin
      mem_sel_q <= rd_in & ref_space;
      rd_q <= `OCCT_ZERO32;
      if (rd_in) begin
        if (ch_space) begin
          case (off_sel)
            `OCCT_OFF_DATA: rd_q <= data_q[ch_sel];
            `OCCT_OFF_CMD: rd_q <= {23'h000000, prev_q[ch_sel]};
            `OCCT_OFF_STAT: rd_q <= stat_word;
            `OCCT_OFF_ECHO: rd_q <= terminal_block_out[ch_sel*32 +: 32];
            default: rd_q <= `OCCT_ZERO32;
          endcase
        end else if (addr_in[7:4] == `OCCT_ADDR_STAMP_BASE >> 4) begin
          rd_q <= {17'h00000, stamp_q[addr_in[3:2]]};
        end else if (addr_in == `OCCT_ADDR_MSCNT) begin
          rd_q <= {17'h00000, ms_cnt_q};
        end
      end
    end
  end

  assign rdata_out = mem_sel_q ? mem_rd : rd_q;
endmodule

/* File: occt_top_assertions.sv */
// concurrent checks on the calibration tag block ports
`include "occt_consts.vh"
module occt_chk #(
  parameter MS_CYCLES = 10
) (
  input wire clock_in,
  input wire rst_n_in,
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  input wire conn_open_in,
  input wire [3:0] low_clamp_alarm_in,
  input wire [3:0] high_clamp_alarm_in,
  input wire [3:0] slew_alarm_in,
  input wire [127:0] terminal_block_out,
  input wire [3:0] calibrating_out,
  input wire [3:0] low_clamp_alarm_out,
  input wire [3:0] high_clamp_alarm_out,
  input wire [3:0] slew_alarm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // command word write of channel 0, the one channel the bench calibrates to completion
  wire cmd0_wr = wr_in && (addr_in == 8'h04);
  // calibrating channel asked for the low or high reference point
  sequence s_lo_req;
    cmd0_wr && calibrating_out[0] && (wdata_in[8:0] == 9'h003);
  endsequence
  sequence s_hi_req;
    cmd0_wr && calibrating_out[0] && (wdata_in[8:0] == 9'h005);
  endsequence
  a_read_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_cal_start_flag: assert property (
    cmd0_wr && !calibrating_out[0] && wdata_in[0] |=> calibrating_out[0])
    else $error("calibrate command did not start calibration");
  a_cal_abandon_flag: assert property (
    cmd0_wr && calibrating_out[0] && !wdata_in[0] |=> !calibrating_out[0])
    else $error("calibrating flag stayed after abandon");
  a_cal_flag_cause: assert property ($changed(calibrating_out[0]) |-> $past(cmd0_wr))
    else $error("calibrating flag moved without an update");
  a_low_alarm_set: assert property (low_clamp_alarm_in[0] |=> low_clamp_alarm_out[0])
    else $error("low alarm event not latched");
  a_high_release_cause: assert property (
    $fell(high_clamp_alarm_out[0]) |-> $past(cmd0_wr && wdata_in[7]))
    else $error("high alarm released without release command");
  a_slew_release_cause: assert property (
    $fell(slew_alarm_out[0]) |-> $past(cmd0_wr && wdata_in[8]))
    else $error("slew alarm released without release command");
  a_drive_change_cause: assert property (
    $changed(terminal_block_out[31:0]) |-> $past(wr_in && addr_in[7:4] == 4'h0, 2))
    else $error("terminal value changed without a channel 0 update");
  a_drive_low_point: assert property (
    s_lo_req |=> ##1 terminal_block_out[31:0] == `OCCT_LO_POINT)
    else $error("low reference point not driven");
  a_drive_high_point: assert property (
    s_hi_req |=> ##1 terminal_block_out[31:0] == `OCCT_HI_POINT)
    else $error("high reference point not driven");
endmodule
bind occt_top occt_chk #(.MS_CYCLES(MS_CYCLES)) occt_chk_i (.clock_in(clock_in),
  .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .conn_open_in(conn_open_in),
  .low_clamp_alarm_in(low_clamp_alarm_in), .high_clamp_alarm_in(high_clamp_alarm_in),
  .slew_alarm_in(slew_alarm_in), .terminal_block_out(terminal_block_out),
  .calibrating_out(calibrating_out), .low_clamp_alarm_out(low_clamp_alarm_out),
  .high_clamp_alarm_out(high_clamp_alarm_out), .slew_alarm_out(slew_alarm_out));

/* File: tb_top.sv */
// self-checking bench for the calibration tag block
`include "occt_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg clock_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg conn_open_in = 1'b1;
  reg [11:0] alm_in = 12'h000; // slew, high, low events, four channels each
  wire [7:0] addr;
  wire [31:0] wdata;
  wire [31:0] rdata;
  wire wr_strobe;
  wire rd;
  wire [127:0] term;
  wire [3:0] caling;
  wire [11:0] alm_out;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int k;
  reg [31:0] rv, t0, t1;
  always #5 clock_in = ~clock_in;
  occt_ctrl_model occt_ctrl_model_i (.clock_in(clock_in), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr_strobe), .rd_out(rd), .rdata_in(rdata));
  // a short millisecond keeps the counter checks quick
  occt_top #(.MS_CYCLES(10)) occt_top_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr_strobe), .rd_in(rd), .rdata_out(rdata),
    .conn_open_in(conn_open_in), .low_clamp_alarm_in(alm_in[3:0]),
    .high_clamp_alarm_in(alm_in[7:4]), .slew_alarm_in(alm_in[11:8]),
    .terminal_block_out(term), .calibrating_out(caling), .low_clamp_alarm_out(alm_out[3:0]),
    .high_clamp_alarm_out(alm_out[7:4]), .slew_alarm_out(alm_out[11:8]));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task wr(input [7:0] a, input [31:0] d); occt_ctrl_model_i.bus_wr(a, d); endtask
  task cmd(input [3:0] ch, input [8:0] c); occt_ctrl_model_i.send_cmd(ch, c); endtask
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  // read a register and compare the masked word
  task rd_chk(input [7:0] a, input [31:0] m, input [31:0] exp, input string what);
    occt_ctrl_model_i.bus_rd(a, rv);
    cmp(what, exp, rv & m);
  endtask
  // one-cycle alarm event on channel 0 of alarm kind n
  task pulse(input int n);
    alm_in[4*n] <= 1'b1;
    @(posedge clock_in);
    alm_in[4*n] <= 1'b0;
    @(posedge clock_in);
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish;
    end
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    @(posedge clock_in);
    cmp("calibrating at reset", 32'h0, {28'h0, caling});
    rd_chk(8'h08, 32'hffffffff, 32'h0, "status at reset");
    rd_chk(8'hf0, 32'hffffffff, 32'h0, "unmapped read");
    $display("test reset done");
    // plain output, echo and change stamp
    occt_ctrl_model_i.bus_rd(8'h50, t0);
    wr(8'h00, 32'h3f800000);
    cmd(4'h0, 9'h000);
    @(posedge clock_in);
    cmp("terminal ch0", 32'h3f800000, term[31:0]);
    rd_chk(8'h0c, 32'hffffffff, 32'h3f800000, "echo ch0");
    occt_ctrl_model_i.bus_rd(8'h40, t1);
    occt_ctrl_model_i.bus_rd(8'h50, rv);
    cmp("stamp in window", 32'h1, {31'h0, t1 >= t0 && t1 <= rv});
    occt_ctrl_model_i.bus_rd(8'h50, t0);
    repeat (28) @(posedge clock_in);
    occt_ctrl_model_i.bus_rd(8'h50, t1);
    cmp("ms count step", 32'h3, (t1 - t0) & 32'h7fff);
    cmp("ms count width", 32'h0, t1 & 32'hffff8000);
    $display("test echo done");
    // alarm releases act only on the first rise of their command bit
    for (k = 0; k < 3; k++) begin
      pulse(k);
      cmd(4'h0, 9'h000);
      @(posedge clock_in);
      cmp("alarm held at 0", 32'h1, {31'h0, alm_out[4*k]});
      cmd(4'h0, 9'h040 << k);
      @(posedge clock_in);
      cmp("alarm released", 32'h0, {31'h0, alm_out[4*k]});
      pulse(k);
      cmd(4'h0, 9'h040 << k);
      @(posedge clock_in);
      cmp("alarm kept on steady 1", 32'h1, {31'h0, alm_out[4*k]});
      cmd(4'h0, 9'h000);
      $display("test alarm %0d done", k);
    end
    // successful two-point calibration of channel 0
    cmd(4'h0, 9'h001);
    @(posedge clock_in);
    cmp("calibrating ch0", 32'h1, {31'h0, caling[0]});
    cmd(4'h0, 9'h003);
    @(posedge clock_in);
    cmp("drive low point", `OCCT_LO_POINT, term[31:0]);
    wr(8'h00, 32'h40810000);
    cmd(4'h0, 9'h00b);
    rd_chk(8'h08, 32'h0000000f, 32'h1, "low point flags");
    rd_chk(8'h60, 32'hffffffff, 32'h40810000, "low point word");
    cmd(4'h0, 9'h005);
    @(posedge clock_in);
    cmp("drive high point", `OCCT_HI_POINT, term[31:0]);
    wr(8'h00, 32'h41a10000);
    cmd(4'h0, 9'h015);
    rd_chk(8'h08, 32'h0000000f, 32'h5, "high point flags");
    rd_chk(8'h64, 32'hffffffff, 32'h41a10000, "high point word");
    cmd(4'h0, 9'h035);
    @(posedge clock_in);
    cmp("calibrating ch0 off", 32'h0, {31'h0, caling[0]});
    cmp("drive data after cal", 32'h41a10000, term[31:0]);
    rd_chk(8'h08, 32'h30, 32'h10, "success flag");
    conn_open_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    conn_open_in <= 1'b1;
    rd_chk(8'h08, 32'h10, 32'h0, "success after close");
    $display("test calibration done");
    // bad low point on channel 1, bad high point on channel 2, then abandon
    for (k = 0; k < 2; k++) begin
      cmd(k + 1, 9'h001);
      wr(8'((k + 1) * 16), k ? 32'hff800000 : 32'h7f800000);
      cmd(k + 1, k ? 9'h011 : 9'h009);
      rd_chk(8'((k + 1) * 16 + 8), 32'hf, k ? 32'h8 : 32'h2, "invalid point flag");
      cmd(k + 1, 9'h000);
      @(posedge clock_in);
      cmp("calibrating off", 32'h0, {31'h0, caling[k + 1]});
      rd_chk(8'((k + 1) * 16 + 8), 32'h20, 32'h20, "fault flag");
      $display("test fault %0d done", k);
    end
    cmd(4'h1, 9'h040);
    rd_chk(8'h18, 32'h20, 32'h20, "fault held");
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    rd_chk(8'h18, 32'h20, 32'h0, "fault after power cycle");
    $display("test power cycle done");
    tally_and_finish;
  end
endmodule
